// file: design/fuse_and_parallel_prog_port.sv
`default_nettype none
// Notes on behaviour
// (RULE1) Three fuse bytes; programmed bits read zero.
// (RULE2) Extended byte: brownout level, reset disable.
// (RULE3) High byte fields and defaults as listed.
// (RULE4) Serial download fuse locked in serial mode.
// (RULE5) Low byte fields; default internal 8 MHz.
// (RULE6) Chip erase leaves fuses unchanged.
// (RULE7) First lock bit programmed blocks fuse writes.
// (RULE8) Fuses captured on programming entry, held.
// (RULE9) Eeprom preserve takes effect immediately.
// (RULE10) Fuses captured at normal power-up.
// (RULE11) Three-byte signature readable even locked.
// (RULE12) Calibration byte copied into register at reset.
// (RULE13) Programmer strobes last at least 250 ns.
// (RULE14) Ready/busy low while busy, high ready.
// (RULE15) Data bus driven only while enable low.
// (RULE16) Byte selects choose low/high/second high.
// (RULE17) Page load latches data into page buffer.
// (RULE18) Entry pattern: four pins all zero.
// (RULE19) Load strobe decodes action select bits.
// (RULE20) Write/enable strobes run latched command.
// (RULE21) Command byte decode as listed.
// (RULE22) Flash 256 pages; eeprom 256 small pages.
// (RULE23) Write strobe starts op; busy until done.
// (RULE24) Bus released while output enable high.
module fuse_and_parallel_prog_port
  import fuse_prog_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0   = 8'hA5, // Arbitrary identity value.
  parameter logic [7:0] SIG_BYTE1   = 8'h5A, // Arbitrary identity value.
  parameter logic [7:0] SIG_BYTE2   = 8'h3C, // Arbitrary identity value.
  parameter logic [7:0] CALIB_BYTE  = 8'h80, // Factory calibration.
  parameter int         PAGE_WORDS  = FLASH_PAGE_WORDS,
  parameter int         EEP_BYTES   = EEP_PAGE_BYTES
) (
  // Clock and reset.
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  // Mode inputs.
  input  wire logic          progModeReq,
  input  wire logic          serialMode,
  // Programming pins, asynchronous to core_clk.
  input  wire prog_pins_t    pins,
  input  wire logic [7:0]    dataIn,
  output logic [7:0]         dataOut,
  output logic               dataOutEnB,
  output logic               ready_busy_out,
  // Device-facing state.
  output fuse_set_t          activeFuses,
  output logic               eepromPreserve,
  output logic [7:0]         osc_calibration_reg,
  output logic               inProgMode,
  output logic [15:0]        address,
  output logic [15:0]        pageBufWord,
  output logic               pageLatchPulse
);
  localparam int WW = $clog2(PAGE_WORDS);
  localparam int BC = $clog2(BUSY_CYC + 1);

  // Reset release through two flops.
  logic rstMeta;
  logic rstSync;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Two-flop synchronisers; the second stage and the edge-history flop are read.
  logic [9:0] syncA;
  logic [9:0] syncB;
  logic [9:0] prevB;
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      // Reset to the idle pin levels, so no false edge follows reset.
      syncA <= 10'h006;
      syncB <= 10'h006;
      prevB <= 10'h006;
    end else begin
      syncA <= {progModeReq, serialMode, pins};
      syncB <= syncA;
      prevB <= syncB;
    end
  end
  logic sProg;
  logic sSerial;
  prog_pins_t sp;
  assign {sProg, sSerial} = syncB[9:8];
  assign sp = prog_pins_t'(syncB[7:0]);
  prog_pins_t pp;
  assign pp = prog_pins_t'(prevB[7:0]);
  logic loadRise;
  logic pageRise;
  logic wrFall;
  assign loadRise = sp.loadStrobe & ~pp.loadStrobe; // [RULE19]
  assign pageRise = sp.pageLoad & ~pp.pageLoad;     // [RULE17]
  assign wrFall = ~sp.writeStrobeB & pp.writeStrobeB; // [RULE23]

  // Data bus samples, also through two flops.
  logic [7:0] dataMeta;
  logic [7:0] dataSync;
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      dataMeta <= 8'h00;
      dataSync <= 8'h00;
    end else begin
      dataMeta <= dataIn;
      dataSync <= dataMeta;
    end
  end

  // Programming mode entry needs the all-zero entry pattern.
  logic entryOk;
  assign entryOk = ~sp.pageLoad & ~sp.actionSelect1 &
                   ~sp.actionSelect0 & ~sp.byteSelectOne; // [RULE18]
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      inProgMode <= 1'b0;
    end else if (!sProg) begin
      inProgMode <= 1'b0;
    end else if (!inProgMode && entryOk) begin
      inProgMode <= 1'b1;
    end
  end

  // Address, data and command latches on the load strobe.
  logic [7:0] command;
  logic [7:0] dataLo;
  logic [7:0] dataHi;
  logic       busy;
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      command <= 8'h00;
      address <= 16'h0000;
      dataLo  <= 8'h00;
      dataHi  <= 8'h00;
    end else if (inProgMode && loadRise) begin
      case (action_t'({sp.actionSelect1, sp.actionSelect0})) // [RULE19]
        ACT_LOAD_ADDR: begin
          if (sp.byteSelectOne) begin                    // [RULE16]
            address[15:8] <= dataSync;
          end else begin
            address[7:0] <= dataSync;
          end
        end
        ACT_LOAD_DATA: begin
          if (sp.byteSelectOne) begin                    // [RULE16]
            dataHi <= dataSync;
          end else begin
            dataLo <= dataSync;
          end
        end
        ACT_LOAD_CMD: begin
          // New commands wait for ready; loads while busy are dropped.
          if (!busy) begin
            command <= dataSync;                         // [RULE23]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Page buffer of flip-flops; word index from low address bits.
  logic [15:0] pageBuf [PAGE_WORDS];
  logic [WW-1:0] wordIdx;
  assign wordIdx = address[WW-1:0];                      // [RULE22]
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        pageBuf[i] <= 16'hFFFF;
      end
      pageLatchPulse <= 1'b0;
    end else begin
      pageLatchPulse <= 1'b0;
      if (inProgMode && pageRise && (command == CMD_WRITE_FLASH ||
          command == CMD_WRITE_EEP)) begin
        pageBuf[wordIdx] <= {dataHi, dataLo};            // [RULE17]
        pageLatchPulse <= 1'b1;
      end
    end
  end
  assign pageBufWord = pageBuf[wordIdx];

  // Stored fuses and locks; only the fuse-write command touches fuses.
  fuse_set_t  fuseStore;
  logic [7:0] lockBits;
  logic       fuseWrite;
  assign fuseWrite = inProgMode && wrFall && !busy &&
                     command == CMD_WRITE_FUSE &&
                     lockBits[FIRST_LOCK_BIT];           // [RULE7]
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      fuseStore <= '{EXT_FUSE_RESET, HIGH_FUSE_RESET,
                     LOW_FUSE_RESET};                    // [RULE1] [RULE2]
    end else if (fuseWrite) begin                        // [RULE6]
      case ({sp.byteSelectTwo, sp.byteSelectOne})        // [RULE16]
        2'b00: fuseStore.low <= dataLo;                  // [RULE5]
        2'b01: begin
          fuseStore.high <= dataLo;                      // [RULE3]
          if (sSerial) begin
            // Serial download fuse keeps its value in serial mode.
            fuseStore.high[SERIAL_DOWNLOAD_BIT] <=
              fuseStore.high[SERIAL_DOWNLOAD_BIT];       // [RULE4]
          end
        end
        2'b10: fuseStore.ext <= dataLo | EXT_UNUSED_MASK; // [RULE2]
        default: begin
        end
      endcase
    end
  end

  // Lock bits: programmed by write-lock, erased only by chip erase.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      lockBits <= LOCK_RESET;
    end else if (inProgMode && wrFall && !busy) begin
      if (command == CMD_WRITE_LOCK) begin
        lockBits <= lockBits & dataLo;
      end else if (command == CMD_CHIP_ERASE) begin
        lockBits <= LOCK_RESET;                          // [RULE6]
      end
    end
  end

  // Captured fuse image: every cycle while out of programming mode with no request, and on programming entry.
  logic progPrev;
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      activeFuses <= '{EXT_FUSE_RESET, HIGH_FUSE_RESET, LOW_FUSE_RESET};
      progPrev    <= 1'b0;
    end else begin
      progPrev <= inProgMode;
      if (!progPrev && !inProgMode && !sProg) begin
        activeFuses <= fuseStore;                        // [RULE10]
      end else if (inProgMode && !progPrev) begin
        activeFuses <= fuseStore;                        // [RULE8]
      end
    end
  end
  // Preserve fuse acts at once when programmed.
  assign eepromPreserve = ~fuseStore.high[EEPROM_PRESERVE_BIT] |
                          ~activeFuses.high[EEPROM_PRESERVE_BIT]; // [RULE9]

  // Calibration copy each cycle outside programming mode; reset loads zero.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      osc_calibration_reg <= 8'h00;
    end else if (!progPrev && !inProgMode) begin
      osc_calibration_reg <= CALIB_BYTE;                 // [RULE12]
    end
  end

  // Busy timer started by the write strobe.
  logic [BC-1:0] busyCnt;
  assign busy = busyCnt != '0;
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      busyCnt <= '0;
    end else if (inProgMode && wrFall && !busy &&
                 (command[7:4] != 4'h0)) begin           // [RULE23]
      busyCnt <= BC'(BUSY_CYC);
    end else if (busy) begin
      busyCnt <= busyCnt - 1'b1;
    end
  end
  assign ready_busy_out = ~busy;                         // [RULE14]

  // Read data selected by latched command and byte selects.
  logic [7:0] next_dataOut;
  always_comb begin
    next_dataOut = 8'hFF;
    case (command)                                       // [RULE20] [RULE21]
      CMD_READ_SIG: begin
        if (sp.byteSelectOne) begin
          next_dataOut = CALIB_BYTE;                     // [RULE12]
        end else begin
          case (address[1:0])                            // [RULE11]
            SIG_ADDR0: next_dataOut = SIG_BYTE0;
            SIG_ADDR1: next_dataOut = SIG_BYTE1;
            SIG_ADDR2: next_dataOut = SIG_BYTE2;
            default:   next_dataOut = 8'hFF;
          endcase
        end
      end
      CMD_READ_FUSE: begin
        case ({sp.byteSelectTwo, sp.byteSelectOne})      // [RULE1]
          2'b00:   next_dataOut = fuseStore.low;
          2'b11:   next_dataOut = fuseStore.high;
          2'b10:   next_dataOut = fuseStore.ext;
          default: next_dataOut = lockBits;
        endcase
      end
      CMD_READ_FLASH: begin
        next_dataOut = sp.byteSelectOne ? pageBufWord[15:8]
                                        : pageBufWord[7:0];
      end
      CMD_READ_EEP: begin
        next_dataOut = pageBufWord[7:0];
      end
      default: begin
        next_dataOut = 8'hFF;
      end
    endcase
  end

  // Registered read data and bus drive enable (low means driving).
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      dataOut    <= 8'h00;
      dataOutEnB <= 1'b1;
    end else begin
      dataOut    <= next_dataOut;
      dataOutEnB <= ~(inProgMode && !sp.outputEnableB); // [RULE15] [RULE24]
    end
  end
endmodule // fuse_and_parallel_prog_port
`default_nettype wire

// file: design/fuse_prog_pkg.sv
`default_nettype none
package fuse_prog_pkg;
  // Fuse byte reset images; a zero bit means programmed.
  localparam logic [7:0] EXT_FUSE_RESET  = 8'hFF;
  localparam logic [7:0] HIGH_FUSE_RESET = 8'h99;
  localparam logic [7:0] LOW_FUSE_RESET  = 8'h62;
  // Field positions.
  localparam int BROWNOUT_LEVEL_HI_BIT  = 2;
  localparam int BROWNOUT_LEVEL_LO_BIT  = 1;
  localparam int EXT_RESET_DISABLE_BIT  = 0;
  localparam int ONCHIP_DEBUG_BIT       = 7;
  localparam int SCAN_PORT_BIT          = 6;
  localparam int SERIAL_DOWNLOAD_BIT    = 5;
  localparam int WATCHDOG_ON_BIT        = 4;
  localparam int EEPROM_PRESERVE_BIT    = 3;
  localparam int RESET_VECTOR_BIT       = 0;
  localparam int CLOCK_DIV8_BIT         = 7;
  localparam int CLOCK_OUT_BIT          = 6;
  localparam int FIRST_LOCK_BIT         = 0;
  localparam logic [7:0] LOCK_RESET     = 8'hFF;
  localparam logic [7:0] EXT_UNUSED_MASK = 8'hF8;
  // Signature space addresses.
  localparam logic [1:0] SIG_ADDR0 = 2'h0;
  localparam logic [1:0] SIG_ADDR1 = 2'h1;
  localparam logic [1:0] SIG_ADDR2 = 2'h2;
  // Action select coding on the load strobe.
  typedef enum logic [1:0] {
    ACT_LOAD_ADDR = 2'b00,
    ACT_LOAD_DATA = 2'b01,
    ACT_LOAD_CMD  = 2'b10,
    ACT_IDLE      = 2'b11
  } action_t;
  // Command byte coding.
  localparam logic [7:0] CMD_CHIP_ERASE  = 8'h80;
  localparam logic [7:0] CMD_WRITE_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WRITE_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
  localparam logic [7:0] CMD_WRITE_EEP   = 8'h11;
  localparam logic [7:0] CMD_READ_SIG    = 8'h08;
  localparam logic [7:0] CMD_READ_FUSE   = 8'h04;
  localparam logic [7:0] CMD_READ_FLASH  = 8'h02;
  localparam logic [7:0] CMD_READ_EEP    = 8'h03;
  // Page geometry.
  localparam int FLASH_PAGES      = 256;
  localparam int FLASH_PAGE_WORDS = 64;
  localparam int EEP_PAGE_BYTES   = 4;
  // Strobe minimum and busy time.
  localparam int STROBE_MIN_NS  = 250;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int BUSY_CYC       = 64;
  // Captured fuse set that steers the device.
  typedef struct packed {
    logic [7:0] ext;
    logic [7:0] high;
    logic [7:0] low;
  } fuse_set_t;
  // Programming pin group.
  typedef struct packed {
    logic       pageLoad;
    logic       actionSelect1;
    logic       actionSelect0;
    logic       byteSelectOne;
    logic       byteSelectTwo;
    logic       writeStrobeB;
    logic       outputEnableB;
    logic       loadStrobe;
  } prog_pins_t;
endpackage
`default_nettype wire

// file: dv/fuse_prog_chk.sv
`default_nettype none
module fuse_prog_chk
  import fuse_prog_pkg::*;
#(
  parameter logic [7:0] CALIB_BYTE = 8'h80
) (
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       rst_b,
  // Watched ports.
  input wire prog_pins_t pins,
  input wire logic       dataOutEnB,
  input wire logic       ready_busy_out,
  input wire fuse_set_t  activeFuses,
  input wire logic       inProgMode,
  input wire logic [7:0] osc_calibration_reg,
  input wire logic       pageLatchPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Counts low cycles of ready, since a long busy run is too big to unroll.
  int busyCnt;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busyCnt <= 0;
    end else begin
      busyCnt <= ready_busy_out ? 0 : busyCnt + 1;
    end
  end
  property p_busy_len;
    $rose(ready_busy_out) |-> busyCnt == BUSY_CYC;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy span has the wrong length");
  property p_busy_cause;
    $fell(ready_busy_out) |-> !$past(pins.writeStrobeB, 2) && inProgMode;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy began without a write strobe");
  property p_release;
    pins.outputEnableB [*5] |-> dataOutEnB;
  endproperty
  a_release: assert property (p_release)
    else $error("data bus driven while output enable is high");
  property p_drive_mode;
    !dataOutEnB |-> inProgMode;
  endproperty
  a_drive_mode: assert property (p_drive_mode)
    else $error("data bus driven outside programming mode");
  property p_fuse_hold;
    inProgMode && $past(inProgMode) |-> $stable(activeFuses);
  endproperty
  a_fuse_hold: assert property (p_fuse_hold)
    else $error("active fuses changed in programming mode");
  property p_page;
    pageLatchPulse |-> inProgMode && $past(pins.pageLoad) ##1 !pageLatchPulse;
  endproperty
  a_page: assert property (p_page)
    else $error("page latch pulse without page load or too long");
  property p_calib;
    inProgMode |-> osc_calibration_reg == CALIB_BYTE;
  endproperty
  a_calib: assert property (p_calib)
    else $error("calibration byte not copied after reset");
  property p_ext_unused;
    (activeFuses.ext & EXT_UNUSED_MASK) == EXT_UNUSED_MASK;
  endproperty
  a_ext_unused: assert property (p_ext_unused)
    else $error("unused extended fuse bits not one");
  // Main scenarios that the bench is expected to reach.
  c_busy: cover property ($fell(ready_busy_out));
  c_page: cover property (pageLatchPulse);
  c_drive: cover property (!dataOutEnB);
endmodule // fuse_prog_chk
bind fuse_and_parallel_prog_port fuse_prog_chk #(.CALIB_BYTE(CALIB_BYTE))
  u_chk (.core_clk, .rst_b, .pins, .dataOutEnB, .ready_busy_out,
         .activeFuses, .inProgMode, .osc_calibration_reg, .pageLatchPulse);
`default_nettype wire

// file: dv/prog_host_model.sv
`default_nettype none
module prog_host_model
  import fuse_prog_pkg::*;
(
  // Clock used only to time the strobes.
  input  wire logic       core_clk,
  // Pins towards the device.
  output var prog_pins_t  pins,
  output wire logic [7:0] dataIn,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOutEnB
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drv; // Byte the programmer puts on the bus.
  // A bus nobody drives shows the inverse, so stale data cannot pass.
  assign dataIn = !dataOutEnB ? dataOut :
                  pins.outputEnableB ? drv : ~drv;
  // Entry pattern all zero, strobes idle.
  initial begin
    pins = 8'h06;
    drv = 8'h00;
  end
  // Every pulse and gap lasts 26 cycles, above the minimum width.
  task automatic hold;
    repeat (26) @(negedge core_clk);
  endtask
  task automatic ld(input action_t a, input logic b1, input logic [7:0] d);
    @(negedge core_clk);
    {pins.actionSelect1, pins.actionSelect0} = a;
    pins.byteSelectOne = b1;
    drv = d;
    hold();
    pins.loadStrobe = 1'b1;
    hold();
    pins.loadStrobe = 1'b0;
    hold();
  endtask
  task automatic wr(input logic b2, input logic b1);
    @(negedge core_clk);
    {pins.byteSelectTwo, pins.byteSelectOne} = {b2, b1};
    pins.writeStrobeB = 1'b0;
    hold();
    pins.writeStrobeB = 1'b1;
  endtask
  task automatic rd(input logic b2, input logic b1, output logic [7:0] d);
    @(negedge core_clk);
    {pins.byteSelectTwo, pins.byteSelectOne} = {b2, b1};
    pins.outputEnableB = 1'b0;
    // The enable pulse must be as wide as any other strobe.
    hold();
    d = dataIn;
    pins.outputEnableB = 1'b1;
    hold();
  endtask
  task automatic pl;
    @(negedge core_clk);
    pins.pageLoad = 1'b1;
    hold();
    pins.pageLoad = 1'b0;
    hold();
  endtask
endmodule // prog_host_model
`default_nettype wire

// file: dv/fuse_and_parallel_prog_port_tb.sv
`default_nettype none
module fuse_and_parallel_prog_port_tb
  import fuse_prog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identity and calibration values.
  localparam logic [7:0] SIG0 = 8'hC3;
  localparam logic [7:0] SIG1 = 8'h4B;
  localparam logic [7:0] SIG2 = 8'h17;
  localparam logic [7:0] CAL  = 8'h6D;
  logic        core_clk = 1'b0;
  logic        rst_b, progModeReq, serialMode, dataOutEnB, ready_busy_out;
  logic        eepromPreserve, inProgMode, pageLatchPulse;
  prog_pins_t  pins;
  fuse_set_t   activeFuses;
  logic [7:0]  dataIn, dataOut, osc_calibration_reg, v;
  logic [15:0] address, pageBufWord;
  int          errorCnt = 0;
  int          checkCount = 0;
  always #5 core_clk = ~core_clk;
  fuse_and_parallel_prog_port #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1),
    .SIG_BYTE2(SIG2), .CALIB_BYTE(CAL)) DUT (.core_clk, .rst_b,
    .progModeReq, .serialMode, .pins, .dataIn, .dataOut, .dataOutEnB,
    .ready_busy_out, .activeFuses, .eepromPreserve, .osc_calibration_reg,
    .inProgMode, .address, .pageBufWord, .pageLatchPulse);
  prog_host_model host (.core_clk, .pins, .dataIn, .dataOut, .dataOutEnB);
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Busy must have fallen; then wait, bounded, for ready.
  task automatic waitr;
    int n = 0;
    chk(ready_busy_out, 0);
    while (ready_busy_out !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    chk(ready_busy_out, 1);
  endtask
  task automatic closeOut;
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog, well beyond the few thousand cycles the tests need.
  initial begin
    #400000;
    errorCnt++;
    closeOut();
  end
  initial begin
    {rst_b, progModeReq, serialMode} = 3'b000;
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (10) @(negedge core_clk);
    chk(activeFuses.ext, EXT_FUSE_RESET);
    chk(activeFuses.high, HIGH_FUSE_RESET);
    chk(activeFuses.low, LOW_FUSE_RESET);
    chk(osc_calibration_reg, CAL);
    chk(eepromPreserve, 0);
    progModeReq = 1'b1;
    repeat (10) @(negedge core_clk);
    chk(inProgMode, 1);
    $display("end of reset and entry test");
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_READ_SIG);
    for (int i = 0; i < 3; i++) begin
      host.ld(ACT_LOAD_ADDR, 1'b0, 8'(i));
      host.rd(1'b0, 1'b0, v);
      chk(v, 8'({SIG2, SIG1, SIG0} >> (8 * i)));
    end
    host.ld(ACT_LOAD_ADDR, 1'b0, 8'h00);
    host.rd(1'b0, 1'b1, v);
    chk(v, CAL);
    $display("end of signature test");
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_WRITE_FLASH);
    host.ld(ACT_LOAD_ADDR, 1'b0, 8'h05);
    host.ld(ACT_LOAD_DATA, 1'b0, 8'h34);
    host.ld(ACT_LOAD_DATA, 1'b1, 8'h12);
    host.ld(ACT_IDLE, 1'b0, 8'hAA);
    host.pl();
    chk(pageBufWord, 16'h1234);
    chk(address[7:0], 8'h05);
    // Read the latched word back, then load and read an eeprom byte.
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_READ_FLASH);
    host.rd(1'b0, 1'b0, v);
    chk(v, 8'h34);
    host.rd(1'b0, 1'b1, v);
    chk(v, 8'h12);
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_WRITE_EEP);
    host.ld(ACT_LOAD_DATA, 1'b0, 8'h56);
    host.pl();
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_READ_EEP);
    host.rd(1'b0, 1'b0, v);
    chk(v, 8'h56);
    $display("end of page load test");
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_WRITE_FUSE);
    host.ld(ACT_LOAD_DATA, 1'b0, HIGH_FUSE_RESET & ~8'h08);
    host.wr(1'b0, 1'b1);
    waitr();
    chk(eepromPreserve, 1);
    chk(activeFuses.high, HIGH_FUSE_RESET);
    host.ld(ACT_LOAD_DATA, 1'b0, 8'h05);
    host.wr(1'b1, 1'b0);
    waitr();
    host.ld(ACT_LOAD_DATA, 1'b0, 8'h61);
    host.wr(1'b0, 1'b0);
    waitr();
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_CHIP_ERASE);
    host.wr(1'b0, 1'b0);
    waitr();
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_READ_FUSE);
    host.rd(1'b0, 1'b0, v);
    chk(v, 8'h61);
    host.rd(1'b1, 1'b1, v);
    chk(v, 8'h91);
    host.rd(1'b1, 1'b0, v);
    chk(v, 8'hFD);
    $display("end of fuse write and erase test");
    serialMode = 1'b1;
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_WRITE_FUSE);
    host.ld(ACT_LOAD_DATA, 1'b0, 8'hB0);
    host.wr(1'b0, 1'b1);
    waitr();
    serialMode = 1'b0;
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_WRITE_LOCK);
    host.ld(ACT_LOAD_DATA, 1'b0, 8'hFE);
    host.wr(1'b0, 1'b0);
    waitr();
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_WRITE_FUSE);
    host.ld(ACT_LOAD_DATA, 1'b0, 8'hFF);
    host.wr(1'b0, 1'b1);
    waitr();
    host.ld(ACT_LOAD_CMD, 1'b0, CMD_READ_FUSE);
    host.rd(1'b0, 1'b1, v);
    chk(v, 8'hFE);
    host.rd(1'b1, 1'b1, v);
    chk(v, 8'h90);
    $display("end of serial and lock test");
    progModeReq = 1'b0;
    repeat (10) @(negedge core_clk);
    chk(inProgMode, 0);
    chk(activeFuses, {8'hFD, 8'h90, 8'h61});
    $display("end of exit test");
    closeOut();
  end
endmodule // fuse_and_parallel_prog_port_tb
`default_nettype wire
